// file: csfr_core_regs.sv
/*
  core special function registers and general purpose port registers.
  assumes a single core clock, pins asynchronous to it, and a core that
  issues at most one special register access per cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module csfr_core_regs
  import csfr_pkg::*;
#(
  parameter int PINS = 22
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire csfr_pkg::csfr_access_t sfr_acc_i,
  input wire csfr_pkg::csfr_core_op_t core_op_i,
  input wire logic [PINS-1:0] pin_i,
  output logic [7:0] sfr_rdata_o,
  output logic [7:0] accumulator_o,
  output logic [7:0] multiply_scratch_o,
  output logic [7:0] program_status_word_o,
  output logic [7:0] stack_top_pointer_o,
  output logic [15:0] data_address_pointer_o,
  output logic [15:0] program_counter_o,
  output logic [4:0] bank_base_o,
  output logic [15:0] ext_indirect_addr_hi_o,
  output logic [7:0] interrupt_request_control_o,
  output logic [7:0] baud_rate_control_o,
  output logic [PINS-1:0] pin_o,
  output logic [PINS-1:0] pin_oe_o
);

  if (PINS != PIN_COUNT) begin : g_pins_check
    $error("csfr_core_regs: pin count must match the three ports");
  end

  logic [7:0] acc_r, acc_nxt;
  logic [7:0] b_r, b_nxt;
  logic [7:0] psw_r, psw_nxt;
  logic [7:0] sp_r, sp_nxt;
  logic [15:0] data_address_pointer_r, data_address_pointer_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] usr_hi_r, irq_ctl_r, baud_r;
  logic [7:0] p0_r, p1_r, p2_r, d0_r, d1_r, d2_r;
  logic [7:0] rdata_r, rdata_nxt;
  logic [PINS-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_level_r;

  // address decode
  wire wr = sfr_acc_i.wr;
  wire [7:0] wd = sfr_acc_i.wdata;
  wire [7:0] ad = sfr_acc_i.addr;
  wire wr_acc = wr && ad == ADDR_ACCUMULATOR;
  wire wr_b = wr && ad == ADDR_MULTIPLY_SCRATCH_REG;
  wire wr_psw = wr && ad == ADDR_PROGRAM_STATUS_WORD;
  wire wr_sp = wr && ad == ADDR_STACK_TOP_POINTER;
  wire wr_dpl = wr && ad == ADDR_DATA_POINTER_LOW;
  wire wr_dph = wr && ad == ADDR_DATA_POINTER_HIGH;
  wire wr_usr = wr && ad == ADDR_EXT_HIGH_ADDRESS_BYTE;
  wire wr_irq = wr && ad == ADDR_INTERRUPT_REQUEST_CONTROL;
  wire wr_baud = wr && ad == ADDR_BAUD_RATE_CONTROL;
  wire wr_p0 = wr && ad == ADDR_PORT0_LATCH;
  wire wr_p1 = wr && ad == ADDR_PORT1_LATCH;
  wire wr_p2 = wr && ad == ADDR_PORT2_LATCH;
  wire wr_d0 = wr && ad == ADDR_PORT0_DIRECTION;
  wire wr_d1 = wr && ad == ADDR_PORT1_DIRECTION;
  wire wr_d2 = wr && ad == ADDR_PORT2_DIRECTION;

  // register writes from the bus take priority over core loads in the same cycle
  always_comb begin
    acc_nxt = acc_r;
    if (wr_acc) begin
      acc_nxt = wd;
    end else if (core_op_i.acc_load) begin
      acc_nxt = core_op_i.acc_value;
    end
    b_nxt = b_r;
    if (wr_b) begin
      b_nxt = wd;
    end else if (core_op_i.b_load) begin
      b_nxt = core_op_i.b_value;
    end
  end

  // parity follows the next accumulator so it never lags by a cycle
  always_comb begin
    psw_nxt = psw_r;
    if (wr_psw) begin
      psw_nxt = wd;
    end else if (core_op_i.flags_load) begin
      psw_nxt[PSW_CARRY_FLAG] = core_op_i.carry;
      psw_nxt[PSW_BCD_HALF_CARRY] = core_op_i.half_carry;
      psw_nxt[PSW_OVERFLOW_FLAG] = core_op_i.overflow;
    end
    psw_nxt[PSW_PARITY] = ^acc_nxt;
  end

  always_comb begin
    sp_nxt = sp_r;
    if (wr_sp) begin
      sp_nxt = wd;
    end else if (core_op_i.sp_inc) begin
      sp_nxt = sp_r + 8'h01;
    end else if (core_op_i.sp_dec) begin
      sp_nxt = sp_r - 8'h01;
    end
    data_address_pointer_nxt = data_address_pointer_r;
    if (core_op_i.data_address_pointer_load) begin
      data_address_pointer_nxt = core_op_i.data_address_pointer_value;
    end
    if (wr_dpl) begin
      data_address_pointer_nxt[7:0] = wd;
    end
    if (wr_dph) begin
      data_address_pointer_nxt[15:8] = wd;
    end
    pc_nxt = pc_r;
    if (core_op_i.pc_load) begin
      pc_nxt = core_op_i.pc_value;
    end else if (core_op_i.pc_inc) begin
      pc_nxt = pc_r + 16'h0001;
    end
  end

  // read mux; ports return synchronised pin levels, not the latch
  always_comb begin
    unique case (ad)
      ADDR_ACCUMULATOR: rdata_nxt = acc_r;
      ADDR_MULTIPLY_SCRATCH_REG: rdata_nxt = b_r;
      ADDR_PROGRAM_STATUS_WORD: rdata_nxt = psw_r;
      ADDR_STACK_TOP_POINTER: rdata_nxt = sp_r;
      ADDR_DATA_POINTER_LOW: rdata_nxt = data_address_pointer_r[7:0];
      ADDR_DATA_POINTER_HIGH: rdata_nxt = data_address_pointer_r[15:8];
      ADDR_EXT_HIGH_ADDRESS_BYTE: rdata_nxt = usr_hi_r;
      ADDR_INTERRUPT_REQUEST_CONTROL: rdata_nxt = irq_ctl_r;
      ADDR_BAUD_RATE_CONTROL: rdata_nxt = baud_r;
      ADDR_PORT0_LATCH: rdata_nxt = pin_level_r[7:0];
      ADDR_PORT1_LATCH: rdata_nxt = pin_level_r[15:8];
      ADDR_PORT2_LATCH: rdata_nxt = {2'b00, pin_level_r[21:16]};
      ADDR_PORT0_DIRECTION: rdata_nxt = d0_r;
      ADDR_PORT1_DIRECTION: rdata_nxt = d1_r;
      ADDR_PORT2_DIRECTION: rdata_nxt = d2_r;
      default: rdata_nxt = 8'h00;
    endcase
    if (!sfr_acc_i.rd) begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r <= RST_ACCUMULATOR;
      b_r <= RST_MULTIPLY_SCRATCH_REG;
      psw_r <= RST_PROGRAM_STATUS_WORD;
      sp_r <= RST_STACK_TOP_POINTER;
      data_address_pointer_r <= RST_DATA_ADDRESS_POINTER;
      pc_r <= RST_PROGRAM_COUNTER;
      rdata_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
      b_r <= b_nxt;
      psw_r <= psw_nxt;
      sp_r <= sp_nxt;
      data_address_pointer_r <= data_address_pointer_nxt;
      pc_r <= pc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // latch writes land regardless of direction
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      usr_hi_r <= RST_EXT_HIGH_ADDRESS_BYTE;
      irq_ctl_r <= RST_INTERRUPT_REQUEST_CONTROL;
      baud_r <= RST_BAUD_RATE_CONTROL;
      p0_r <= RST_PORT0_LATCH;
      p1_r <= RST_PORT1_LATCH;
      p2_r <= RST_PORT2_LATCH;
      d0_r <= RST_DIRECTION;
      d1_r <= RST_DIRECTION;
      d2_r <= RST_DIRECTION;
    end else begin
      if (wr_usr) usr_hi_r <= wd;
      if (wr_irq) irq_ctl_r <= wd;
      if (wr_baud) baud_r <= {wd[BAUD_RATE_CONTROL_BIT], 7'h00};
      if (wr_p0) p0_r <= wd;
      if (wr_p1) p1_r <= wd;
      if (wr_p2) p2_r <= {2'b00, wd[5:0]};
      if (wr_d0) d0_r <= wd;
      if (wr_d1) d1_r <= wd;
      if (wr_d2) d2_r <= {2'b00, wd[5:0]};
    end
  end

  // pins: three-stage synchroniser, level accepted once stages two and three agree
  wire [PINS-1:0] pin_agree = ~(pin_s2_r ^ pin_s3_r);
  wire [PINS-1:0] latch_all = {p2_r[5:0], p1_r, p0_r};
  wire [PINS-1:0] dir_all = {d2_r[5:0], d1_r, d0_r};

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_level_r <= '0;
    end else begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_level_r <= (pin_agree & pin_s3_r) | (~pin_agree & pin_level_r);
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign accumulator_o = acc_r;
  assign multiply_scratch_o = b_r;
  assign program_status_word_o = psw_r;
  assign stack_top_pointer_o = sp_r;
  assign data_address_pointer_o = data_address_pointer_r;
  assign program_counter_o = pc_r;
  assign bank_base_o = {psw_r[PSW_BANK_SELECT_HIGH], psw_r[PSW_BANK_SELECT_LOW], 3'b000};
  assign ext_indirect_addr_hi_o = {usr_hi_r, 8'h00};
  assign interrupt_request_control_o = irq_ctl_r;
  assign baud_rate_control_o = baud_r;
  // pins follow the latch and direction flops directly, one cycle after the write
  assign pin_o = latch_all;
  assign pin_oe_o = dir_all;

endmodule : csfr_core_regs

`default_nettype wire

// file: csfr_core_regs_monitor.sv
/*
  checker for csfr_core_regs, bound to the design.
  assumes one core clock and the asynchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module csfr_core_regs_monitor
  import csfr_pkg::*;
#(
  parameter int PINS = 22
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire csfr_pkg::csfr_access_t sfr_acc_i,
  input wire csfr_pkg::csfr_core_op_t core_op_i,
  input wire logic [PINS-1:0] pin_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] accumulator_o,
  input wire logic [7:0] multiply_scratch_o,
  input wire logic [7:0] program_status_word_o,
  input wire logic [7:0] stack_top_pointer_o,
  input wire logic [15:0] data_address_pointer_o,
  input wire logic [15:0] program_counter_o,
  input wire logic [4:0] bank_base_o,
  input wire logic [15:0] ext_indirect_addr_hi_o,
  input wire logic [7:0] interrupt_request_control_o,
  input wire logic [7:0] baud_rate_control_o,
  input wire logic [PINS-1:0] pin_o,
  input wire logic [PINS-1:0] pin_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // write address, 00 when idle; 00 is never a register here
  wire logic [7:0] wad = sfr_acc_i.wr ? sfr_acc_i.addr : 8'h00;
  wire logic [7:0] wd = sfr_acc_i.wdata;
  reset_vals_a: assert property ($fell(sys_rst_i) |-> stack_top_pointer_o == 8'h07
    && program_counter_o == 16'h0000) else $error("sp or pc reset value wrong");
  sp_push_a: assert property (core_op_i.sp_inc && wad != 8'h81
    |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01) else $error("sp step");
  pc_step_a: assert property (core_op_i.pc_inc && !core_op_i.pc_load
    |=> program_counter_o == $past(program_counter_o) + 16'h0001) else $error("pc step");
  bank_base_a: assert property (bank_base_o == {program_status_word_o[4:3], 3'h0})
    else $error("bank base wrong");
  parity_bit_a: assert property (program_status_word_o[0] == ^accumulator_o)
    else $error("parity wrong");
  acc_write_a: assert property (wad == 8'he0 |=> accumulator_o == $past(wd))
    else $error("acc write lost");
  data_address_pointer_low_a: assert property (wad == 8'h82 |=> data_address_pointer_o[7:0] == $past(wd))
    else $error("data_address_pointer low write lost");
  ext_byte_a: assert property (wad == 8'hbf |=> ext_indirect_addr_hi_o == {$past(wd), 8'h00})
    else $error("ext byte wrong");
  baud_bits_a: assert property (baud_rate_control_o[6:0] == 7'h00)
    else $error("baud unused bits set");
  dir_write_a: assert property (wad == 8'ha2 |=> pin_oe_o[7:0] == $past(wd))
    else $error("port0 direction wrong");
  latch_out_a: assert property (wad == 8'h80 |=> pin_o[7:0] == $past(wd))
    else $error("port0 latch wrong");
endmodule : csfr_core_regs_monitor
bind csfr_core_regs csfr_core_regs_monitor #(.PINS(PINS)) u_mon (.sys_clk_i, .sys_rst_i,
  .sfr_acc_i, .core_op_i, .pin_i, .sfr_rdata_o, .accumulator_o, .multiply_scratch_o,
  .program_status_word_o, .stack_top_pointer_o, .data_address_pointer_o, .program_counter_o,
  .bank_base_o, .ext_indirect_addr_hi_o, .interrupt_request_control_o, .baud_rate_control_o,
  .pin_o, .pin_oe_o);
`default_nettype wire

// file: csfr_core_regs_test.sv
/*
  self-checking bench for csfr_core_regs with pin model and checker.
  assumes a 40 MHz core clock and asynchronous high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module csfr_core_regs_test;
  import csfr_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  csfr_access_t bus = '0;
  csfr_core_op_t cop = '0;
  csfr_core_op_t o;
  logic [21:0] ext = '0;
  logic [21:0] lvl, pin_o, oe;
  logic [7:0] rdata, a_o, b_o, program_status_word, sp, irq, baud, d, m;
  logic [15:0] data_address_pointer, pc, ehi;
  logic [4:0] bank;
  int miscompares = 0;
  int num_checks = 0;
  int seed = 32'h4e909d6b;
  int i;
  localparam logic [7:0] LAT [3] = '{8'h80, 8'h90, 8'ha0};
  localparam logic [7:0] DIR [3] = '{8'ha2, 8'h91, 8'ha1};
  csfr_core_regs #(.PINS(22)) i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .sfr_acc_i(bus), .core_op_i(cop), .pin_i(lvl), .sfr_rdata_o(rdata), .accumulator_o(a_o),
    .multiply_scratch_o(b_o), .program_status_word_o(program_status_word), .stack_top_pointer_o(sp),
    .data_address_pointer_o(data_address_pointer), .program_counter_o(pc), .bank_base_o(bank),
    .ext_indirect_addr_hi_o(ehi), .interrupt_request_control_o(irq),
    .baud_rate_control_o(baud), .pin_o(pin_o), .pin_oe_o(oe));
  csfr_pin_model #(.PINS(22)) i_pins (.drv_i(pin_o), .oe_i(oe), .ext_i(ext), .level_o(lvl));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  function automatic logic par(logic [7:0] v);
    return ^v;
  endfunction : par
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk_i) bus <= '{w, ~w, a, v};
    @(posedge sys_clk_i) bus <= '0;
    @(negedge sys_clk_i);
  endtask : acc
  task automatic op(csfr_core_op_t x);
    @(posedge sys_clk_i) cop <= x;
    @(posedge sys_clk_i) cop <= '0;
    @(negedge sys_clk_i);
  endtask : op
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // no handshake waits exist, so one run limit is the bound
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("sp", 8'h07, sp);
    chk("pc", 16'h0000, pc);
    chk("acc", 8'h00, a_o);
    chk("psw", 8'h00, program_status_word);
    chk("irq", 8'h00, irq);
    chk("ext", 16'h0000, ehi);
    chk("baud", 8'h00, baud);
    acc(1'b0, 8'hff, 8'h00);
    chk("unmapped", 8'h00, rdata);
    $display("test reset done");
    o = '0;
    o.sp_inc = 1'b1;
    op(o);
    chk("sp push", 8'h08, sp);
    o = '0;
    o.pc_inc = 1'b1;
    repeat (3) op(o);
    chk("pc", 16'h0003, pc);
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hff : 8'($random(seed));
      acc(1'b1, 8'he0, d);
      chk("acc", d, a_o);
      chk("parity", par(d), program_status_word[0]);
    end
    for (i = 0; i < 4; i++) begin
      d = {3'h5, i[1:0], 3'h2};
      acc(1'b1, 8'hd0, d);
      chk("bank", {i[1:0], 3'h0}, bank);
      chk("psw", d[7:1], program_status_word[7:1]);
    end
    o = '0;
    o.flags_load = 1'b1;
    o.half_carry = 1'b1;
    o.overflow = 1'b1;
    op(o);
    chk("flags", 3'h3, {program_status_word[7:6], program_status_word[2]});
    o = '0;
    o.acc_load = 1'b1;
    o.acc_value = 8'h07;
    o.b_load = 1'b1;
    o.b_value = 8'h3c;
    o.sp_dec = 1'b1;
    o.pc_load = 1'b1;
    o.pc_value = 16'h1234;
    op(o);
    chk("acc load", 8'h07, a_o);
    chk("parity", 1'b1, program_status_word[0]);
    chk("b load", 8'h3c, b_o);
    chk("sp pop", 8'h07, sp);
    chk("pc load", 16'h1234, pc);
    acc(1'b0, 8'he0, 8'h00);
    chk("acc read", 8'h07, rdata);
    acc(1'b1, 8'hc0, 8'h81);
    chk("irq", 8'h81, irq);
    $display("test core done");
    o = '0;
    o.data_address_pointer_load = 1'b1;
    o.data_address_pointer_value = 16'($random(seed));
    op(o);
    chk("data_address_pointer", o.data_address_pointer_value, data_address_pointer);
    acc(1'b1, 8'h82, 8'h5a);
    acc(1'b1, 8'h83, 8'hc3);
    chk("data_address_pointer", 16'hc35a, data_address_pointer);
    acc(1'b1, 8'hf0, 8'h96);
    chk("b", 8'h96, b_o);
    acc(1'b1, 8'hbf, 8'ha5);
    chk("ext", 16'ha500, ehi);
    acc(1'b1, 8'hd8, 8'hff);
    chk("baud", 8'h80, baud);
    $display("test registers done");
    for (i = 0; i < 3; i++) begin
      m = (i == 2) ? 8'h3f : 8'hff;
      d = 8'($random(seed));
      @(posedge sys_clk_i) ext <= 22'($random(seed));
      acc(1'b1, LAT[i], d);
      repeat (6) @(negedge sys_clk_i);
      acc(1'b0, LAT[i], 8'h00);
      chk("input", 8'(ext >> (8 * i)) & m, rdata);
      acc(1'b1, DIR[i], 8'hff);
      chk("oe", m, 8'(oe >> (8 * i)));
      chk("pin", d & m, 8'(pin_o >> (8 * i)));
      repeat (6) @(negedge sys_clk_i);
      acc(1'b0, LAT[i], 8'h00);
      chk("readback", d & m, rdata);
    end
    $display("test ports done");
    finish_test();
  end
endmodule : csfr_core_regs_test
`default_nettype wire

// file: csfr_pin_model.sv
/*
  pins and outside circuitry of the general purpose ports.
  assumes outside parts drive only pins the chip leaves as inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module csfr_pin_model #(
  parameter int PINS = 22
) (
  input wire logic [PINS-1:0] drv_i,
  input wire logic [PINS-1:0] oe_i,
  input wire logic [PINS-1:0] ext_i,
  output logic [PINS-1:0] level_o
);
  // a driven pin shows the chip's level, so it reads back as driven
  assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : csfr_pin_model
`default_nettype wire

// file: csfr_pkg.sv
/*
  package for the core special function register group: register
  addresses, reset values, status word field positions, access carriers.
  assumes an 8-bit direct special register address space.
*/
package csfr_pkg;

  localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] ADDR_STACK_TOP_POINTER = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_PORT1_DIRECTION = 8'h91;
  localparam logic [7:0] ADDR_PORT2_LATCH = 8'ha0;
  localparam logic [7:0] ADDR_PORT2_DIRECTION = 8'ha1;
  localparam logic [7:0] ADDR_PORT0_DIRECTION = 8'ha2;
  localparam logic [7:0] ADDR_EXT_HIGH_ADDRESS_BYTE = 8'hbf;
  localparam logic [7:0] ADDR_INTERRUPT_REQUEST_CONTROL = 8'hc0;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_BAUD_RATE_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'he0;
  localparam logic [7:0] ADDR_MULTIPLY_SCRATCH_REG = 8'hf0;

  localparam logic [7:0] RST_PORT0_LATCH = 8'hff;
  localparam logic [7:0] RST_PORT1_LATCH = 8'hff;
  localparam logic [7:0] RST_PORT2_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [15:0] RST_DATA_ADDRESS_POINTER = 16'h0000;
  localparam logic [15:0] RST_PROGRAM_COUNTER = 16'h0000;
  localparam logic [7:0] RST_EXT_HIGH_ADDRESS_BYTE = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_REQUEST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PROGRAM_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_BAUD_RATE_CONTROL = 8'h00;
  localparam logic [7:0] RST_ACCUMULATOR = 8'h00;
  localparam logic [7:0] RST_MULTIPLY_SCRATCH_REG = 8'h00;

  localparam int PSW_CARRY_FLAG = 7;
  localparam int PSW_BCD_HALF_CARRY = 6;
  localparam int PSW_USER_FLAG_ZERO = 5;
  localparam int PSW_BANK_SELECT_HIGH = 4;
  localparam int PSW_BANK_SELECT_LOW = 3;
  localparam int PSW_OVERFLOW_FLAG = 2;
  localparam int PSW_USER_FLAG_ONE = 1;
  localparam int PSW_PARITY = 0;
  localparam int BAUD_RATE_CONTROL_BIT = 7;

  localparam int PORT0_PINS = 8;
  localparam int PORT1_PINS = 8;
  localparam int PORT2_PINS = 6;
  localparam int PIN_COUNT = 22;

  // special register access from the core, one per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csfr_access_t;

  // operations the executing core requests in a cycle
  typedef struct packed {
    logic sp_inc;
    logic sp_dec;
    logic pc_inc;
    logic pc_load;
    logic [15:0] pc_value;
    logic data_address_pointer_load;
    logic [15:0] data_address_pointer_value;
    logic acc_load;
    logic [7:0] acc_value;
    logic b_load;
    logic [7:0] b_value;
    logic flags_load;
    logic carry;
    logic half_carry;
    logic overflow;
  } csfr_core_op_t;

endpackage : csfr_pkg
